// >>> hw/option_map_and_eprom_program_control.sv
`timescale 1ns/1ps
module option_map_and_eprom_program_control
  import option_map_pkg::*;
#(
  parameter bit EPROM_VARIANT = 1'b1
)
(
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  input  wire logic        option_map_select_in,
  input  wire logic        user_mode_in,
  input  wire logic        port_d_high_select_in,
  input  wire logic        port_e_high_select_in,
  input  wire logic        port_e_low_select_in,
  input  wire logic [2:0]  lcd_backplane_pin_in,
  input  wire logic        reset_pin_pullup_option_in,
  input  wire logic        main_osc_feedback_option_in,
  input  wire logic        sub_osc_resistor_option_in,
  input  wire logic [7:0]  eprom_rdata_in,
  output logic [7:0]       rdata_out,
  output logic             reg_hit_out,
  output logic             main_reg_sel_out,
  output logic             ram_sel_out,
  output logic             boot_rom_sel_out,
  output logic             prog_mem_sel_out,
  output logic             prog_read_en_out,
  output logic             prog_write_latch_out,
  output logic [15:0]      prog_addr_latched_out,
  output logic [7:0]       prog_data_latched_out,
  output logic             program_power_on_out,
  output logic [7:0]       port_a_direction_out,
  output logic [7:0]       port_c_direction_out,
  output logic [7:0]       port_d_pin_function_out,
  output logic [7:0]       port_e_pin_function_out,
  output logic [7:0]       port_a_pullup_out,
  output logic [7:0]       port_b_pullup_out,
  output logic [7:0]       port_c_line_pullup_out,
  output logic [7:0]       port_a_open_drain_out,
  output logic [7:0]       port_c_open_drain_out,
  output logic [7:4]       port_d_high_open_drain_out,
  output logic [3:1]       port_d_low_open_drain_out,
  output logic [7:0]       port_e_open_drain_out,
  output logic [7:0]       key_wake_line_enable_out
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire logic in_low16   = (addr_in <= OPT_MAP_LAST);
  wire logic opt_space  = in_low16 && option_map_select_in;
  wire logic sel_dir_a  = opt_space && (addr_in == ADDR_PORTA_DIR);
  wire logic sel_dir_c  = opt_space && (addr_in == ADDR_PORTC_DIR);
  wire logic sel_fn_d   = opt_space && (addr_in == ADDR_PORTD_FUNC);
  wire logic sel_fn_e   = opt_space && (addr_in == ADDR_PORTE_FUNC);
  wire logic sel_pu_ab  = opt_space && (addr_in == ADDR_PULLUP_AB);
  wire logic sel_pu_c   = opt_space && (addr_in == ADDR_PULLUP_C);
  wire logic sel_od1    = opt_space && (addr_in == ADDR_OD_FIRST);
  wire logic sel_od2    = opt_space && (addr_in == ADDR_OD_SECOND);
  wire logic sel_kw     = opt_space && (addr_in == ADDR_KWAKE_EN);
  // the status and program control registers exist on one variant each
  wire logic sel_mos    = opt_space && (addr_in == ADDR_MASK_OPT) && !EPROM_VARIANT;
  wire logic sel_pcr    = (addr_in == ADDR_PROG_CTRL) && EPROM_VARIANT;
  wire logic in_ram     = (addr_in >= RAM_FIRST) && (addr_in <= RAM_LAST);
  wire logic in_boot    = (addr_in >= BOOT_FIRST) && (addr_in <= BOOT_LAST);
  wire logic in_prog    = ((addr_in >= PROG_FIRST) && (addr_in <= PROG_LAST))
                          || (addr_in >= VEC_FIRST);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]  dir_a_q;
  logic [7:0]  dir_c_q;
  logic [7:0]  fn_d_q;
  logic [7:0]  fn_e_q;
  logic [7:0]  pu_ab_q;
  logic [7:0]  pu_c_q;
  logic [7:0]  od1_q;
  logic [7:0]  od2_q;
  logic [7:0]  kw_q;
  logic [7:0]  pcr_q;
  logic [7:0]  pcr_d;
  logic [15:0] lat_addr_q;
  logic [7:0]  lat_data_q;
  logic [7:0]  mos_q;
  logic [2:0]  opt_meta_q;
  logic [2:0]  opt_sync_q;

  wire logic latch_on  = pcr_q[BIT_PROG_LATCH];
  // power needs both bits; a single write clearing both drops power at once
  always_comb
  begin
    pcr_d = pcr_q;
    if (wr_in && sel_pcr)
    begin
      pcr_d = wdata_in & PROG_CTRL_MASK;
      if (!pcr_d[BIT_PROG_LATCH])
      begin
        pcr_d[BIT_PROG_POWER] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      dir_a_q <= RESET_BYTE;
      dir_c_q <= RESET_BYTE;
      fn_d_q  <= RESET_BYTE;
      fn_e_q  <= RESET_BYTE;
      pu_ab_q <= RESET_BYTE;
      pu_c_q  <= RESET_BYTE;
      od1_q   <= RESET_BYTE;
      od2_q   <= RESET_BYTE;
      kw_q    <= RESET_BYTE;
      pcr_q   <= RESET_BYTE;
    end
    else
    begin
      if (wr_in && sel_dir_a) dir_a_q <= wdata_in;
      if (wr_in && sel_dir_c) dir_c_q <= wdata_in;
      if (wr_in && sel_fn_d)  fn_d_q  <= wdata_in & PORTD_FUNC_MASK;
      if (wr_in && sel_fn_e)  fn_e_q  <= wdata_in;
      if (wr_in && sel_pu_ab) pu_ab_q <= wdata_in & PULLUP_AB_MASK;
      if (wr_in && sel_pu_c)  pu_c_q  <= wdata_in;
      if (wr_in && sel_od1)   od1_q   <= wdata_in & OD_FIRST_MASK;
      if (wr_in && sel_od2)   od2_q   <= wdata_in & OD_SECOND_MASK;
      if (wr_in && sel_kw)    kw_q    <= wdata_in;
      pcr_q <= pcr_d;
    end
  end

  // latched address and data carry no control meaning; reset only keeps them defined
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      lat_addr_q <= 16'h0000;
      lat_data_q <= RESET_BYTE;
    end
    else if (wr_in && in_prog && latch_on && EPROM_VARIANT)
    begin
      lat_addr_q <= addr_in;
      lat_data_q <= wdata_in;
    end
  end

  // straps are pins outside the clock domain: two flops before the status register reads them
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      opt_meta_q <= 3'h0;
      opt_sync_q <= 3'h0;
      mos_q      <= RESET_BYTE;
    end
    else
    begin
      opt_meta_q <= {reset_pin_pullup_option_in, main_osc_feedback_option_in, sub_osc_resistor_option_in};
      opt_sync_q <= opt_meta_q;
      mos_q      <= {opt_sync_q, 5'h00} & MASK_OPT_MASK;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  wire logic [7:0] pcr_view = user_mode_in ? (pcr_q & PROG_CTRL_MASK) : pcr_q;
  wire logic [7:0] prog_view = latch_on ? ERASED_BYTE : eprom_rdata_in;
  logic [7:0] rdata_d;
  always_comb
  begin
    rdata_d = RESET_BYTE;
    if (sel_dir_a)      rdata_d = dir_a_q;
    else if (sel_dir_c) rdata_d = dir_c_q;
    else if (sel_fn_d)  rdata_d = fn_d_q;
    else if (sel_fn_e)  rdata_d = fn_e_q;
    else if (sel_pu_ab) rdata_d = pu_ab_q;
    else if (sel_pu_c)  rdata_d = pu_c_q;
    else if (sel_od1)   rdata_d = od1_q;
    else if (sel_od2)   rdata_d = od2_q | OD_SECOND_ONES;
    else if (sel_kw)    rdata_d = kw_q;
    else if (sel_mos)   rdata_d = mos_q;
    else if (sel_pcr)   rdata_d = pcr_view;
    else if (in_prog)   rdata_d = prog_view;
  end

  logic [7:0] rdata_q;
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rdata_q <= RESET_BYTE;
    end
    else if (rd_in)
    begin
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign rdata_out             = rdata_q;
  assign reg_hit_out           = opt_space || sel_pcr;
  assign main_reg_sel_out      = in_low16 && !option_map_select_in;
  assign ram_sel_out           = in_ram;
  assign boot_rom_sel_out      = in_boot;
  assign prog_mem_sel_out      = in_prog;
  assign prog_read_en_out      = in_prog && rd_in && !latch_on;
  assign prog_write_latch_out  = latch_on;
  assign prog_addr_latched_out = lat_addr_q;
  assign prog_data_latched_out = lat_data_q;
  assign program_power_on_out  = pcr_q[BIT_PROG_POWER] && pcr_q[BIT_PROG_LATCH];
  assign port_a_direction_out  = dir_a_q;
  assign port_c_direction_out  = dir_c_q;
  assign port_d_pin_function_out = fn_d_q;
  assign port_e_pin_function_out = fn_e_q;
  assign port_a_pullup_out     = {{4{pu_ab_q[BIT_PU_A_HIGH]}}, {4{pu_ab_q[BIT_PU_A_LOW]}}};
  assign port_b_pullup_out     = {{4{pu_ab_q[BIT_PU_B_HIGH]}}, {4{pu_ab_q[BIT_PU_B_LOW]}}};
  assign port_c_line_pullup_out = pu_c_q;
  assign port_a_open_drain_out = dir_a_q & {{4{od1_q[BIT_OD_A_HIGH]}},
                                            {4{od1_q[BIT_OD_A_LOW]}}};
  assign port_c_open_drain_out = dir_c_q & (od2_q | OD_SECOND_ONES);
  assign port_d_high_open_drain_out = {4{od1_q[BIT_OD_D_HIGH] && port_d_high_select_in}};
  assign port_d_low_open_drain_out  = {3{od1_q[BIT_OD_D_LOW]}} & ~lcd_backplane_pin_in;
  assign port_e_open_drain_out = {{4{od1_q[BIT_OD_E_HIGH] && port_e_high_select_in}},
                                  {4{od1_q[BIT_OD_E_LOW] && port_e_low_select_in}}};
  assign key_wake_line_enable_out = kw_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_power_needs_latch: assert property (@(posedge clk_in) disable iff (!nrst_in)
    pcr_q[BIT_PROG_POWER] |-> pcr_q[BIT_PROG_LATCH])
    else $error("program power bit set without latch");
  a_no_read_latched: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (rd_in && in_prog && latch_on) |-> (!prog_read_en_out ##1 (rdata_out == ERASED_BYTE)))
    else $error("program read served while latched");
  a_latch_capture: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (wr_in && in_prog && latch_on) |=> (prog_addr_latched_out == $past(addr_in)))
    else $error("write address not captured");
  a_od2_ones: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (rd_in && sel_od2) |=> (rdata_out[7:6] == 2'b11))
    else $error("second open-drain high bits not one");
  a_pu_ab_upper: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (rd_in && sel_pu_ab) |=> (rdata_out[7:4] == 4'h0))
    else $error("pull-up upper bits not zero");
  a_od1_gap: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (rd_in && sel_od1) |=> (rdata_out[3:2] == 2'b00))
    else $error("first open-drain bits 3,2 not zero");
  a_overlay_hides: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (wr_in && main_reg_sel_out) |=> (port_a_direction_out == $past(port_a_direction_out)))
    else $error("option register written with overlay off");
  a_dir_write: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (wr_in && sel_dir_a) |=> (port_a_direction_out == $past(wdata_in)))
    else $error("port A direction write lost");
  a_pcr_upper: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (rd_in && sel_pcr && user_mode_in) |=> (rdata_out[7:2] == 6'h00))
    else $error("program control upper bits not zero");

  // register writes land one cycle later
  a_dir_c_write: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (wr_in && sel_dir_c) |=> (port_c_direction_out == $past(wdata_in)))
    else $error("port C direction write lost");

  a_pu_c_write: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (wr_in && sel_pu_c) |=> (port_c_line_pullup_out == $past(wdata_in)))
    else $error("port C pull-up write lost");

  a_kw_write: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (wr_in && sel_kw) |=> (key_wake_line_enable_out == $past(wdata_in)))
    else $error("key wake enable write lost");

  a_latch_data: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (wr_in && in_prog && latch_on) |=> (prog_data_latched_out == $past(wdata_in)))
    else $error("write data not captured");

  a_latch_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !(wr_in && in_prog && latch_on) |=> $stable(prog_data_latched_out))
    else $error("latched data changed without capture");

  a_fn_d_low: assert property (@(posedge clk_in) disable iff (!nrst_in)
    port_d_pin_function_out[3:0] == 4'h0)
    else $error("port D function low bits not zero");

  // read values of fixed, absent and reserved locations
  a_mos_low: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (rd_in && sel_mos) |=> (rdata_out[4:0] == 5'h00))
    else $error("mask status low bits not zero");

  a_mos_absent: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (rd_in && opt_space && (addr_in == ADDR_MASK_OPT) && EPROM_VARIANT) |=> (rdata_out == RESET_BYTE))
    else $error("mask status visible on eprom build");

  a_pcr_absent: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (rd_in && (addr_in == ADDR_PROG_CTRL) && !EPROM_VARIANT) |=> (rdata_out == RESET_BYTE))
    else $error("program control visible on mask build");

  a_reserved_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (rd_in && opt_space && (addr_in[3:0] inside {4'h1, 4'h5, 4'h6, 4'h7, 4'hC, 4'hD}))
    |=> (rdata_out == RESET_BYTE))
    else $error("reserved location not zero");

  // open-drain enables follow direction, lcd ownership and the port selects
  a_od_a_dir: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (port_a_open_drain_out & ~port_a_direction_out) == 8'h00)
    else $error("port A open-drain on an input line");

  a_od_c_dir: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (port_c_open_drain_out & ~port_c_direction_out) == 8'h00)
    else $error("port C open-drain on an input line");

  a_od_c_top: assert property (@(posedge clk_in) disable iff (!nrst_in)
    port_c_open_drain_out[7:6] == port_c_direction_out[7:6])
    else $error("port C lines 7,6 not open-drain as outputs");

  a_od_d_high: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !port_d_high_select_in |-> (port_d_high_open_drain_out == 4'h0))
    else $error("port D high open-drain without port select");

  a_od_d_low: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (port_d_low_open_drain_out & lcd_backplane_pin_in) == 3'h0)
    else $error("port D low open-drain on backplane line");

  a_od_e_high: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !port_e_high_select_in |-> (port_e_open_drain_out[7:4] == 4'h0))
    else $error("port E high open-drain without port select");

  a_od_e_low: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !port_e_low_select_in |-> (port_e_open_drain_out[3:0] == 4'h0))
    else $error("port E low open-drain without port select");

  // program power follows the control writes
  a_power_write: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (wr_in && sel_pcr && wdata_in[BIT_PROG_LATCH] && wdata_in[BIT_PROG_POWER]) |=> program_power_on_out)
    else $error("program power not switched on");

  a_power_off: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (wr_in && sel_pcr && !wdata_in[BIT_PROG_POWER]) |=> !program_power_on_out)
    else $error("program power not switched off");

  a_power_forced: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (wr_in && sel_pcr && !wdata_in[BIT_PROG_LATCH]) |=> !program_power_on_out)
    else $error("program power on with latch clear");
endmodule

// >>> hw/option_map_pkg.sv
package option_map_pkg;
  localparam logic [15:0] ADDR_PORTA_DIR   = 16'h0000;
  localparam logic [15:0] ADDR_PORTC_DIR   = 16'h0002;
  localparam logic [15:0] ADDR_PORTD_FUNC  = 16'h0003;
  localparam logic [15:0] ADDR_PORTE_FUNC  = 16'h0004;
  localparam logic [15:0] ADDR_PULLUP_AB   = 16'h0008;
  localparam logic [15:0] ADDR_PULLUP_C    = 16'h0009;
  localparam logic [15:0] ADDR_OD_FIRST    = 16'h000A;
  localparam logic [15:0] ADDR_OD_SECOND   = 16'h000B;
  localparam logic [15:0] ADDR_KWAKE_EN    = 16'h000E;
  localparam logic [15:0] ADDR_MASK_OPT    = 16'h000F;
  localparam logic [15:0] ADDR_PROG_CTRL   = 16'h003D;
  localparam logic [15:0] OPT_MAP_LAST     = 16'h000F;
  localparam logic [15:0] RAM_FIRST        = 16'h0040;
  localparam logic [15:0] RAM_LAST         = 16'h023F;
  localparam logic [15:0] BOOT_FIRST       = 16'hFE00;
  localparam logic [15:0] BOOT_LAST        = 16'hFFEF;
  localparam logic [15:0] PROG_FIRST       = 16'h1000;
  localparam logic [15:0] PROG_LAST        = 16'h4FFF;
  localparam logic [15:0] VEC_FIRST        = 16'hFFF0;
  localparam logic [7:0]  ERASED_BYTE      = 8'hFF;
  localparam logic [7:0]  RESET_BYTE       = 8'h00;
  localparam logic [7:0]  PULLUP_AB_MASK   = 8'h0F;
  localparam logic [7:0]  OD_FIRST_MASK    = 8'hF3;
  localparam logic [7:0]  OD_SECOND_ONES   = 8'hC0;
  localparam logic [7:0]  OD_SECOND_MASK   = 8'h3F;
  localparam logic [7:0]  PROG_CTRL_MASK   = 8'h03;
  localparam logic [7:0]  MASK_OPT_MASK    = 8'hE0;
  localparam logic [7:0]  PORTD_FUNC_MASK  = 8'hF0;
  localparam int          BIT_PROG_POWER   = 0;
  localparam int          BIT_PROG_LATCH   = 1;
  localparam int          BIT_OD_A_LOW     = 0;
  localparam int          BIT_OD_A_HIGH    = 1;
  localparam int          BIT_OD_E_LOW     = 4;
  localparam int          BIT_OD_E_HIGH    = 5;
  localparam int          BIT_OD_D_LOW     = 6;
  localparam int          BIT_OD_D_HIGH    = 7;
  localparam int          BIT_PU_A_LOW     = 0;
  localparam int          BIT_PU_A_HIGH    = 1;
  localparam int          BIT_PU_B_LOW     = 2;
  localparam int          BIT_PU_B_HIGH    = 3;
endpackage

// >>> verification/eprom_array_model.sv
`timescale 1ns/1ps
module eprom_array_model
(
  input  wire logic        clk_in,
  input  wire logic [15:0] addr_in,
  input  wire logic        sel_in,
  input  wire logic        power_in,
  input  wire logic [15:0] prog_addr_in,
  input  wire logic [7:0]  prog_data_in,
  output logic [7:0]       rdata_out
);
  logic [7:0] cells [65536];
  logic [7:0] idle_q;

  // erased cells read all ones
  initial
  begin
    idle_q = 8'h5A;
    foreach (cells[j]) cells[j] = 8'hFF;
  end

  // programming can only clear bits, as in a real floating-gate cell
  always @(posedge clk_in)
  begin
    idle_q <= ~idle_q;
    if (power_in)
      cells[prog_addr_in] <= cells[prog_addr_in] & prog_data_in;
  end

  // unselected array gives a toggling pattern, never the last value
  always_comb rdata_out = sel_in ? cells[addr_in] : idle_q;
endmodule

// >>> verification/option_map_and_eprom_program_control_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module option_map_and_eprom_program_control_tb;
  import option_map_pkg::*;
  logic        clk_in, nrst_in, wr_in, rd_in, optsel, port_d_high_select, port_e_high_select, port_e_low_select, hit, msel, rsel, bsel, psel, plat, pwr;
  logic [15:0] addr_in, pa, pg;
  logic [7:0]  wdata_in, rdata_out, rdata2, erd, pd, adir, cdir, dfun, apu, bpu, cpu, aod, cod, eod, kw, d;
  logic [7:4]  dhod;
  logic [3:1]  dlod;
  logic        pren, um;
  logic [7:0]  efun;
  logic [2:0]  bp, mo;
  logic [7:0]  sh [16];
  logic [15:0] ra [13] = '{16'h003F, 16'h0040, 16'h023F, 16'h0240, 16'h0FFF, 16'h1000, 16'h4FFF, 16'h5000,
                           16'hFDFF, 16'hFE00, 16'hFFEF, 16'hFFF0, 16'hFFFF};
  logic [2:0]  re [13] = '{3'b000, 3'b100, 3'b100, 3'b000, 3'b000, 3'b001, 3'b001, 3'b000,
                           3'b000, 3'b010, 3'b010, 3'b001, 3'b001};
  int          failures, total_checks, seed, i, k;

  option_map_and_eprom_program_control #(.EPROM_VARIANT(1'b1)) dut
  (
    .clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .option_map_select_in(optsel), .user_mode_in(um), .port_d_high_select_in(port_d_high_select), .port_e_high_select_in(port_e_high_select),
    .port_e_low_select_in(port_e_low_select), .lcd_backplane_pin_in(bp), .reset_pin_pullup_option_in(mo[2]),
    .main_osc_feedback_option_in(mo[1]), .sub_osc_resistor_option_in(mo[0]), .eprom_rdata_in(erd),
    .rdata_out(rdata_out), .reg_hit_out(hit), .main_reg_sel_out(msel), .ram_sel_out(rsel), .boot_rom_sel_out(bsel),
    .prog_mem_sel_out(psel), .prog_read_en_out(pren), .prog_write_latch_out(plat), .prog_addr_latched_out(pa),
    .prog_data_latched_out(pd), .program_power_on_out(pwr), .port_a_direction_out(adir),
    .port_c_direction_out(cdir), .port_d_pin_function_out(dfun), .port_e_pin_function_out(efun),
    .port_a_pullup_out(apu), .port_b_pullup_out(bpu), .port_c_line_pullup_out(cpu), .port_a_open_drain_out(aod),
    .port_c_open_drain_out(cod), .port_d_high_open_drain_out(dhod), .port_d_low_open_drain_out(dlod),
    .port_e_open_drain_out(eod), .key_wake_line_enable_out(kw)
  );

  // mask-ROM build shares the bus; only its read data is judged
  option_map_and_eprom_program_control #(.EPROM_VARIANT(1'b0)) mask_dut
  (
    .clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .option_map_select_in(optsel), .user_mode_in(1'b1), .port_d_high_select_in(port_d_high_select), .port_e_high_select_in(port_e_high_select),
    .port_e_low_select_in(port_e_low_select), .lcd_backplane_pin_in(bp), .reset_pin_pullup_option_in(mo[2]),
    .main_osc_feedback_option_in(mo[1]), .sub_osc_resistor_option_in(mo[0]), .eprom_rdata_in(erd),
    .rdata_out(rdata2), .reg_hit_out(), .main_reg_sel_out(), .ram_sel_out(), .boot_rom_sel_out(),
    .prog_mem_sel_out(), .prog_read_en_out(), .prog_write_latch_out(), .prog_addr_latched_out(),
    .prog_data_latched_out(), .program_power_on_out(), .port_a_direction_out(), .port_c_direction_out(),
    .port_d_pin_function_out(), .port_e_pin_function_out(), .port_a_pullup_out(), .port_b_pullup_out(),
    .port_c_line_pullup_out(), .port_a_open_drain_out(), .port_c_open_drain_out(),
    .port_d_high_open_drain_out(), .port_d_low_open_drain_out(), .port_e_open_drain_out(),
    .key_wake_line_enable_out()
  );

  eprom_array_model partner
  (
    .clk_in(clk_in), .addr_in(addr_in), .sel_in(pren), .power_in(pwr), .prog_addr_in(pa), .prog_data_in(pd),
    .rdata_out(erd)
  );

  // ----------------------------------------
  // bus tasks and expectations
  // ----------------------------------------
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_in);
    #2 addr_in = a;
    wdata_in = v;
    wr_in = 1'b1;
    @(posedge clk_in);
    #2 wr_in = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a);
    @(posedge clk_in);
    #2 addr_in = a;
    rd_in = 1'b1;
    @(posedge clk_in);
    #2 rd_in = 1'b0;
  endtask

  function automatic logic [7:0] opt_read(input int i, input logic [7:0] v);
    case (i)
      0, 2, 4, 9, 14: return v;
      3: return v & 8'hF0;
      8: return v & 8'h0F;
      10: return v & 8'hF3;
      11: return {2'b11, v[5:0]};
      default: return 8'h00;
    endcase
  endfunction

  task automatic check_ports();
    `CHK(adir, sh[0])
    `CHK(cdir, sh[2])
    `CHK(dfun, sh[3] & 8'hF0)
    `CHK(apu, {{4{sh[8][1]}}, {4{sh[8][0]}}})
    `CHK(bpu, {{4{sh[8][3]}}, {4{sh[8][2]}}})
    `CHK(cpu, sh[9])
    `CHK(aod, sh[0] & {{4{sh[10][1]}}, {4{sh[10][0]}}})
    `CHK(cod, sh[2] & {2'b11, sh[11][5:0]})
    `CHK(dhod, {4{sh[10][7] & port_d_high_select}})
    `CHK(dlod, {3{sh[10][6]}} & ~bp)
    `CHK(eod, {{4{sh[10][5] & port_e_high_select}}, {4{sh[10][4] & port_e_low_select}}})
    `CHK(kw, sh[14])
    `CHK(efun, sh[4])
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------
  // clock, watchdog and test sequence
  // ----------------------------------------
  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  // the sequence needs about 610 cycles; twenty thousand means a hang
  initial
  begin
    #1_000_000;
    failures++;
    stop_test();
  end

  initial
  begin
    seed = 79;
    {nrst_in, wr_in, rd_in, optsel, port_d_high_select, port_e_high_select, port_e_low_select} = 7'h00;
    addr_in = 16'h0000;
    wdata_in = 8'h00;
    bp = 3'h0;
    um = 1'b1;
    mo = 3'($random(seed));
    repeat (12) @(posedge clk_in);
    #2 nrst_in = 1'b1;
    optsel = 1'b1;
    for (i = 0; i < 16; i++)
    begin
      rd(16'(i));
      `CHK(rdata_out, opt_read(i, 8'h00))
      if (i == 15) `CHK(rdata2, {mo, 5'h00})
      sh[i] = 8'h00;
    end
    rd(ADDR_PROG_CTRL);
    `CHK(rdata_out, 8'h00)
    $display("test reset_values done");
    for (k = 0; k < 8; k++)
    begin
      for (i = 0; i < 16; i++)
      begin
        d = 8'($random(seed));
        wr(16'(i), d);
        sh[i] = d;
        rd(16'(i));
        `CHK(rdata_out, opt_read(i, d))
        if (i == 15) `CHK(rdata2, {mo, 5'h00})
      end
      {port_d_high_select, port_e_high_select, port_e_low_select, bp} = 6'($random(seed));
      #1 check_ports();
    end
    $display("test option_registers done");
    @(posedge clk_in);
    #2 optsel = 1'b0;
    wr(ADDR_PORTA_DIR, ~sh[0]);
    rd(ADDR_PORTC_DIR);
    `CHK(rdata_out, 8'h00)
    `CHK({msel, hit, adir}, {2'b10, sh[0]})
    optsel = 1'b1;
    #1 `CHK({msel, hit}, 2'b01)
    for (i = 0; i < 13; i++)
    begin
      @(posedge clk_in);
      #2 addr_in = ra[i];
      #1 `CHK({rsel, bsel, psel}, re[i])
    end
    $display("test decode done");
    pg = 16'h1000 + 16'($random(seed) & 16'h3FFF);
    d = {1'b0, 7'($random(seed))};
    rd(pg);
    `CHK(rdata_out, 8'hFF)
    wr(ADDR_PROG_CTRL, 8'h01);
    `CHK(pwr, 1'b0)
    wr(ADDR_PROG_CTRL, 8'hFE);
    `CHK({plat, pwr}, 2'b10)
    rd(ADDR_PROG_CTRL);
    `CHK({rdata_out, rdata2}, 16'h0200)
    um = 1'b0;
    rd(ADDR_PROG_CTRL);
    `CHK(rdata_out, 8'h02)
    um = 1'b1;
    wr(pg, d);
    `CHK({pa, pd}, {pg, d})
    wr(ADDR_PROG_CTRL, 8'h03);
    `CHK(pwr, 1'b1)
    repeat (4) @(posedge clk_in);
    wr(ADDR_PROG_CTRL, 8'h00);
    `CHK({plat, pwr}, 2'b00)
    rd(pg);
    `CHK(rdata_out, d)
    wr(ADDR_PROG_CTRL, 8'h02);
    rd(pg);
    `CHK(rdata_out, 8'hFF)
    wr(ADDR_PROG_CTRL, 8'h00);
    $display("test programming done");
    wr(ADDR_PROG_CTRL, 8'h02);
    @(posedge clk_in);
    #2 nrst_in = 1'b0;
    @(posedge clk_in);
    #2 nrst_in = 1'b1;
    `CHK({adir, cdir, dfun, efun, apu, bpu, cpu, kw}, 64'h0)
    `CHK({aod, cod, dhod, dlod, eod, plat, pwr}, 33'h0)
    rd(16'h000B);
    `CHK(rdata_out, 8'hC0)
    $display("test reset_again done");
    stop_test();
  end
endmodule
